// ---- hw/iaf_top.sv ----
// address match / general call / acknowledge flags of a serial bus port
// assumes apb master on REF_CLK_IN; scl and sda arrive asynchronously
//
// Operation
// R1: own or general-call address sets match flag; code sets it only in slave mode with fs 0
// R2: data access or master mode clears flags; code clears in master mode, and on data access only for a write in transmit or a read in receive
// R3: match flag cleared by read-1 then write-0
// R4: general call sets flag when either format-select 0
// R5: general-call flag cleared by read-1 then write-0
// R6: transmit loads acknowledge returned by receiver
// R7: receive drives software acknowledge bit back
// R8: read returns captured or specified ack by direction
// R9: ack on ninth pulse, low means acknowledge
`include "iaf_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module iaf_top (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT
);
  import iaf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, effects at the completing edge
  iaf_ctrl_t   ctrl;
  iaf_status_t flags;
  logic        ack_captured;
  logic        ack_specified;
  logic [7:0]  rx_byte;
  logic [7:0]  data_byte;
  logic        own_flag;
  logic        gc_flag;
  logic        own_armed;
  logic        gc_armed;
  logic        own_set;
  logic        gc_set;
  logic        acc_done;
  logic        rd_done;
  logic        wr_done;
  logic        hit_status;
  logic        hit_data;
  logic        hit_ctrl;
  logic        ack_read;

  assign acc_done   = PSEL_IN & PENABLE_IN & PREADY_OUT;
  assign rd_done    = acc_done & ~PWRITE_IN;
  assign wr_done    = acc_done & PWRITE_IN;
  assign hit_status = (PADDR_IN == `IAF_OFF_STATUS);
  assign hit_data   = (PADDR_IN == `IAF_OFF_DATA);
  assign hit_ctrl   = (PADDR_IN == `IAF_OFF_CTRL);
  assign ack_read   = ctrl.transmit ? ack_captured : ack_specified; // R8

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
    end else begin
      PREADY_OUT  <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT
                     & ~(hit_status | hit_data | hit_ctrl);
      PRDATA_OUT  <= 32'h0000_0000;
      if (PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~PWRITE_IN) begin
        if (hit_status)
          PRDATA_OUT <= {29'h0000_0000, flags.own_address_match_flag,
                         flags.general_call_match_flag, ack_read};
        else if (hit_data)
          PRDATA_OUT <= {24'h00_0000, data_byte};
        else if (hit_ctrl)
          PRDATA_OUT <= {20'h0_0000, ctrl};
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      ctrl          <= `IAF_CTRL_RESET;
      ack_specified <= 1'b0;
    end else if (wr_done & hit_ctrl) begin
      ctrl <= PWDATA_IN[11:0];
    end else if (wr_done & hit_status) begin
      ack_specified <= PWDATA_IN[`IAF_ST_ACK]; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags: arming needs a read that returned 1; set beats every clear
  logic data_clear;
  assign data_clear = hit_data & ((wr_done & ctrl.transmit)
                      | (rd_done & ~ctrl.transmit)); // R2

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      own_armed <= 1'b0;
      gc_armed  <= 1'b0;
    end else if (acc_done & hit_status) begin
      // arm on what the read returned, not on the flag one cycle later
      own_armed <= rd_done & PRDATA_OUT[`IAF_ST_OWN_MATCH]; // R3
      gc_armed  <= rd_done & PRDATA_OUT[`IAF_ST_GC_MATCH]; // R5
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      own_flag <= 1'b0;
    end else if (own_set) begin
      own_flag <= 1'b1; // R1
    end else if (ctrl.master | data_clear) begin
      own_flag <= 1'b0; // R2
    end else if (wr_done & hit_status & own_armed
                 & ~PWDATA_IN[`IAF_ST_OWN_MATCH]) begin
      own_flag <= 1'b0; // R3
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      gc_flag <= 1'b0;
    end else if (gc_set) begin
      gc_flag <= 1'b1; // R4
    end else if (ctrl.master | data_clear) begin
      gc_flag <= 1'b0; // R2
    end else if (wr_done & hit_status & gc_armed
                 & ~PWDATA_IN[`IAF_ST_GC_MATCH]) begin
      gc_flag <= 1'b0; // R5
    end
  end

  // status struct holds the visible value; the raw captured copy lives apart
  assign flags = {own_flag, gc_flag, ack_read};

  ////////////////////////////////////////////////////////////////////////
  // pin sampling: change accepted once stages two and three agree
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic       scl_f;
  logic       sda_f;
  logic       scl_prev;
  logic       sda_prev;

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], SCL_IN};
      sda_sync <= {sda_sync[1:0], SDA_IN};
      if (scl_sync[1] == scl_sync[2])
        scl_f <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_f <= sda_sync[2];
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise   = scl_f & ~scl_prev;
  assign scl_fall   = ~scl_f & scl_prev;
  assign start_seen = scl_f & scl_prev & sda_prev & ~sda_f;
  assign stop_seen  = scl_f & scl_prev & ~sda_prev & sda_f;

  ////////////////////////////////////////////////////////////////////////
  // byte framing and the ninth-pulse acknowledge
  iaf_link_state_t state;
  logic [3:0]      bit_cnt;
  logic            first_frame;
  logic            selected;
  logic            own_hit;
  logic            gc_hit;

  assign own_hit = (rx_byte[7:1] == ctrl.own_addr);
  assign gc_hit  = (rx_byte == `IAF_GEN_CALL_ADDR);
  // evaluated once, the cycle the first frame's ack slot opens
  assign own_set = (state == LK_BYTE) & scl_fall & first_frame
                   & (bit_cnt == `IAF_BITS_PER_BYTE) & ~ctrl.master
                   & ~ctrl.fs & (own_hit | gc_hit); // R1
  assign gc_set  = (state == LK_BYTE) & scl_fall & first_frame
                   & (bit_cnt == `IAF_BITS_PER_BYTE) & ~ctrl.master
                   & gc_hit & (~ctrl.fs | ~ctrl.secondary_format_select); // R4

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      state        <= LK_IDLE;
      bit_cnt      <= 4'h0;
      first_frame  <= 1'b0;
      selected     <= 1'b0;
      rx_byte      <= 8'h00;
      data_byte    <= 8'h00;
      ack_captured <= 1'b0;
      SDA_OE_OUT   <= 1'b0;
      SDA_OUT      <= 1'b0;
    end else if (start_seen) begin
      state       <= LK_BYTE;
      bit_cnt     <= 4'h0;
      first_frame <= 1'b1;
      selected    <= 1'b0;
      SDA_OE_OUT  <= 1'b0;
    end else if (stop_seen) begin
      state      <= LK_IDLE;
      selected   <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end else begin
      SDA_OUT <= `IAF_ACK_LEVEL;
      case (state)
        LK_BYTE: begin
          if (scl_rise & (bit_cnt != `IAF_BITS_PER_BYTE)) begin
            rx_byte <= {rx_byte[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall & (bit_cnt == `IAF_BITS_PER_BYTE)) begin
            state <= LK_ACK;
            // only whole bytes reach software; a stop's lone rise shifts too
            data_byte <= rx_byte;
            if (first_frame) begin
              selected   <= ~ctrl.master & (own_hit | gc_hit);
              SDA_OE_OUT <= ~ctrl.master & (own_hit | gc_hit); // R9
            end else begin
              // open drain: only a low acknowledge is driven
              SDA_OE_OUT <= (selected | ctrl.master) & ~ctrl.transmit
                            & (ack_specified == `IAF_ACK_LEVEL); // R7 R9
            end
          end
        end
        LK_ACK: begin
          if (scl_rise & ctrl.transmit & (ctrl.master | ~first_frame))
            ack_captured <= sda_f; // R6 R9
          if (scl_fall) begin
            SDA_OE_OUT  <= 1'b0;
            bit_cnt     <= 4'h0;
            first_frame <= 1'b0;
            state <= (selected | ctrl.master) ? LK_BYTE : LK_IGNORE;
          end
        end
        LK_IGNORE: state <= LK_IGNORE;
        LK_IDLE:   state <= LK_IDLE;
        default:   state <= LK_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- hw/iaf_defines.svh ----
// offsets, field positions and reset values for the address/ack flag block
// assumes a 32-bit apb word per register, byte addressed
`ifndef IAF_DEFINES_SVH
`define IAF_DEFINES_SVH

`define IAF_OFF_STATUS       8'h00
`define IAF_OFF_DATA         8'h04
`define IAF_OFF_CTRL         8'h08

`define IAF_ST_OWN_MATCH     2
`define IAF_ST_GC_MATCH      1
`define IAF_ST_ACK           0

`define IAF_CT_OWN_ADDR_LSB  0
`define IAF_CT_OWN_ADDR_MSB  6
`define IAF_CT_FSX           8
`define IAF_CT_FS            9
`define IAF_CT_TRANSMIT      10
`define IAF_CT_MASTER        11

`define IAF_CTRL_RESET       12'h000
`define IAF_OWN_ADDR_RESET   7'h00
`define IAF_GEN_CALL_ADDR    8'h00
`define IAF_BITS_PER_BYTE    4'h8
`define IAF_ACK_LEVEL        1'b0

`endif

// ---- hw/iaf_pkg.sv ----
// types shared by the address/ack flag block
// field order matches iaf_defines.svh; widths and state codes are literal here
package iaf_pkg;

  typedef struct packed {
    logic       master;
    logic       transmit;
    logic       fs;
    logic       secondary_format_select;
    logic       spare;
    logic [6:0] own_addr;
  } iaf_ctrl_t;

  typedef struct packed {
    logic own_address_match_flag;
    logic general_call_match_flag;
    logic acknowledge_bit;
  } iaf_status_t;

  typedef enum logic [1:0] {
    LK_IDLE   = 2'b00,
    LK_BYTE   = 2'b01,
    LK_ACK    = 2'b10,
    LK_IGNORE = 2'b11
  } iaf_link_state_t;

endpackage

// ---- bench/iaf_top_chk.sv ----
// port-level checks for the address/ack flag block
// assumes apb master and bus pins as seen at iaf_top
`include "iaf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module iaf_chk (
  input wire logic        REF_CLK_IN,
  input wire logic        RESET_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        SCL_IN,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE_OUT
);
  logic spec, trs, mst, wok;
  // shadow of what software last wrote
  assign wok = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      spec <= 1'b0;
      trs <= 1'b0;
      mst <= 1'b0;
    end else if (wok && PADDR_IN == `IAF_OFF_STATUS) begin
      spec <= PWDATA_IN[0];
    end else if (wok && PADDR_IN == `IAF_OFF_CTRL) begin
      trs <= PWDATA_IN[10];
      mst <= PWDATA_IN[11];
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  sequence setup_s; PSEL_IN && !PENABLE_IN; endsequence
  sequence wait_s; PSEL_IN && PENABLE_IN && !PREADY_OUT; endsequence
  sequence rstat_s; PREADY_OUT && !PWRITE_IN && PADDR_IN == 8'h00; endsequence
  wait_state_a: assert property (setup_s ##1 wait_s |=> PREADY_OUT)
    else $error("apb answer late");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  unmapped_err_a: assert property (PREADY_OUT && PADDR_IN > `IAF_OFF_CTRL
    |-> PSLVERR_OUT && PRDATA_OUT == 32'h0) else $error("unmapped access");
  sda_low_a: assert property (SDA_OUT == 1'b0)
    else $error("sda driven high");
  oe_rise_a: assert property ($rose(SDA_OE_OUT) |-> !SCL_IN)
    else $error("ack drive starts with scl high");
  oe_hold_a: assert property (SDA_OE_OUT && SCL_IN |=> SDA_OE_OUT)
    else $error("ack drive dropped while scl high");
  ack_read_a: assert property ((rstat_s and !trs) |-> PRDATA_OUT[0] == spec)
    else $error("receive ack read differs from written value");
  master_clr_a: assert property ((rstat_s and mst) |-> PRDATA_OUT[2:1] == 2'h0)
    else $error("flags set in master mode");
endmodule
`default_nettype wire

// ---- bench/iaf_bus_model.sv ----
// far-side bus master: start, 9-bit slots, stop
// assumes open-drain wiring with pull-up resolved by the bench
`timescale 1ns/1ps
`default_nettype none
module iaf_bus_model (
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  // scl stands high between frames; 160 ns period
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic start();
    #43 sda_out = 1'b0;
    #40 scl_out = 1'b0;
  endtask
  // a 1 releases sda so the slave may pull it low
  task automatic bits9(input logic [8:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      #40 sda_out = b[i];
      #40 scl_out = 1'b1;
      #40 if (i == 0) ack = sda_in;
      #40 scl_out = 1'b0;
    end
  endtask
  task automatic stop();
    #40 sda_out = 1'b0;
    #40 scl_out = 1'b1;
    #40 sda_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- bench/test_iaf_top.sv ----
// self-checking bench for the address/ack flag block
// assumes iaf_bus_model as far-side master, checker bound below
`include "iaf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_iaf_top;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pw = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pd = 32'h0, prd, q, lf = 32'hCFFA;
  logic        prdy, perr, sda_o, sda_oe, scl, m_sda, sda, ack, err;
  logic [6:0]  own;
  int          errors = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;
  assign sda = (sda_oe ? sda_o : 1'b1) & m_sda;
  iaf_top iaf_top_inst (.REF_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pd),
    .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe));
  iaf_bus_model iaf_bus_model_inst (.scl_out(scl), .sda_out(m_sda),
    .sda_in(sda));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // m is {master, transmit, fs, fsx}
  function automatic logic [31:0] ctl(input logic [3:0] m);
    return {20'h0, m, 1'b0, own};
  endfunction
  function automatic logic [31:0] gcx(input logic [1:0] f);
    return {29'h0, ~f[1], ~(f[1] & f[0]), 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the cycle ceiling ends a wait that never completes
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    q = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic frame(input logic [7:0] b);
    iaf_bus_model_inst.start();
    iaf_bus_model_inst.bits9({b, 1'b1}, ack);
    iaf_bus_model_inst.stop();
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd("status", 8'h00, 32'h0);
    lf = lfsr(lf);
    own = lf[6:0] | 7'h01;
    apb(1'b1, `IAF_OFF_CTRL, ctl(4'b0001));
    frame({own, lf[7]});
    chk("addr ack", 32'h0, {31'h0, ack});
    apb(1'b1, `IAF_OFF_STATUS, 32'h0);
    rd("own flag", 8'h00, 32'h4);
    apb(1'b1, `IAF_OFF_STATUS, 32'h0);
    rd("own clear", 8'h00, 32'h0);
    frame({own, 1'b0});
    rd("data", `IAF_OFF_DATA, {24'h0, own, 1'b0});
    rd("data clear", 8'h00, 32'h0);
    apb(1'b1, `IAF_OFF_CTRL, ctl(4'b0101));
    frame({own, 1'b1});
    apb(1'b0, `IAF_OFF_DATA, 32'h0);
    rd("tx read keeps", 8'h00, 32'h4);
    apb(1'b1, `IAF_OFF_DATA, 32'h0);
    rd("tx write clear", 8'h00, 32'h0);
    $display("own address done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `IAF_OFF_CTRL, ctl(4'(m)));
      frame(8'h00);
      rd("gc flags", 8'h00, gcx(2'(m)));
      apb(1'b1, `IAF_OFF_STATUS, 32'h0);
      rd("gc clear", 8'h00, 32'h0);
    end
    $display("general call done");
    apb(1'b1, `IAF_OFF_CTRL, ctl(4'b0001));
    frame({own, 1'b1});
    apb(1'b1, `IAF_OFF_CTRL, ctl(4'b1001));
    rd("master clear", 8'h00, 32'h0);
    apb(1'b1, `IAF_OFF_CTRL, ctl(4'b0001));
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, `IAF_OFF_STATUS, 32'(s));
      lf = lfsr(lf);
      iaf_bus_model_inst.start();
      iaf_bus_model_inst.bits9({own, 2'b01}, ack);
      iaf_bus_model_inst.bits9({lf[7:0], 1'b1}, ack);
      iaf_bus_model_inst.stop();
      chk("data ack", 32'(s), {31'h0, ack});
    end
    $display("ack drive done");
    apb(1'b1, `IAF_OFF_CTRL, ctl(4'b1100));
    for (int a = 0; a < 2; a++) begin
      lf = lfsr(lf);
      iaf_bus_model_inst.start();
      iaf_bus_model_inst.bits9({lf[7:0], 1'(a)}, ack);
      iaf_bus_model_inst.stop();
      rd("captured ack", 8'h00, 32'(a));
    end
    apb(1'b1, `IAF_OFF_CTRL, ctl(4'b0000));
    rd("specified ack", 8'h00, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, q);
    $display("ack capture done");
    wrap_up();
  end
endmodule
bind iaf_top iaf_chk iaf_chk_inst (.REF_CLK_IN(REF_CLK_IN),
  .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE_OUT(SDA_OE_OUT));
`default_nettype wire
